// [design/qdw_i2c_receiver.sv]
/*
  Serial write receiver of a four-channel converter with an AXI4-Lite register slave.
  Assumes scl_clk is the bus clock pin, also sampled as data, and an external open-drain
  resolution of sda from sda_o and sda_oe.
*/
`timescale 1ns/100ps
module qdw_i2c_receiver
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  output qdw_pkg::qdw_word_t [3:0] chan_out,
  input wire logic [qdw_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [qdw_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  function automatic logic [31:0] word32(input qdw_pkg::qdw_word_t w);
    word32 = {20'h00000, w};
  endfunction : word32

  // Link domain: bits are shifted on every rising bus clock edge.
  logic [7:0] shift_q;
  always_ff @(posedge scl_clk)
  begin
    shift_q <= {shift_q[6:0], sda_i};
  end

  // Pins pass two flip-flops; the third stage only feeds edge detection.
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [3:0] apin_s_q;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      apin_s_q <= 4'h0;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_clk};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      apin_s_q <= {apin_s_q[1:0], addr_pin_hi, addr_pin_lo};
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev, byte_done, ack_end;
  logic [7:0] rx_byte;
  assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
  assign start_ev = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  assign stop_ev = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
  // The shift register is stable from the eighth rising edge until the acknowledge clock
  // rises, which is far longer than the synchroniser delay, so it is read directly here.
  assign rx_byte = shift_q;

  qdw_pkg::qdw_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic ackph_q, ackph_d, oe_q, oe_d, pend_q, pend_d, hs_q, hs_d, ack_d;
  qdw_pkg::qdw_ctrl_t ctrl_q, ctrl_d;
  logic [7:0] hi_q, hi_d, words_q, words_d;
  logic [1:0] lo_q, lo_d;
  qdw_pkg::qdw_word_t [3:0] tmp_q, tmp_d, out_q, out_d;
  qdw_pkg::qdw_word_t new_w;
  logic [2:0] cfg_q, cfg_d;

  assign byte_done = scl_fall & (bit_q == qdw_pkg::BITS_PER_BYTE) & ~ackph_q;
  assign ack_end = scl_fall & ackph_q;

  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    ackph_d = ackph_q;
    oe_d = oe_q;
    pend_d = pend_q;
    hs_d = hs_q;
    ctrl_d = ctrl_q;
    hi_d = hi_q;
    lo_d = lo_q;
    words_d = words_q;
    tmp_d = tmp_q;
    out_d = out_q;
    ack_d = 1'b0;
    if (ctrl_q.powerdown_flag)
      new_w = {hi_q[7:6], 10'h000};
    else
      new_w = {2'h0, hi_q, lo_q};
    if (start_ev)
    begin
      st_d = qdw_pkg::ST_ADDR;
      bit_d = 4'h0;
      ackph_d = 1'b0;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end
    else if (stop_ev)
    begin
      st_d = qdw_pkg::ST_IDLE;
      bit_d = 4'h0;
      ackph_d = 1'b0;
      oe_d = 1'b0;
      pend_d = 1'b0;
      hs_d = 1'b0;
    end
    else if (byte_done)
    begin
      ackph_d = 1'b1;
      case (st_q)
        qdw_pkg::ST_ADDR:
        begin
          // The write bit must be zero; reads are not served and stay unanswered.
          if (cfg_q[qdw_pkg::CFG_EN_BIT] && rx_byte[0] == 1'b0
              && rx_byte[7:1] == {qdw_pkg::ADDR_FIXED, apin_s_q[3:2]})
          begin
            ack_d = 1'b1;
            st_d = qdw_pkg::ST_CTRL;
          end
          else
          begin
            if (rx_byte[7:3] == qdw_pkg::ENTRY_CODE_TOP)
              hs_d = 1'b1;
            st_d = qdw_pkg::ST_SKIP;
          end
        end
        qdw_pkg::ST_CTRL:
        begin
          ctrl_d = rx_byte;
          if (rx_byte[7:6] == cfg_q[qdw_pkg::CFG_EXT_LSB +: 2])
          begin
            ack_d = 1'b1;
            st_d = qdw_pkg::ST_HIGH;
          end
          else
            st_d = qdw_pkg::ST_SKIP;
        end
        qdw_pkg::ST_HIGH:
        begin
          ack_d = 1'b1;
          hi_d = rx_byte;
          st_d = qdw_pkg::ST_LOW;
        end
        qdw_pkg::ST_LOW:
        begin
          ack_d = 1'b1;
          lo_d = rx_byte[7:6];
          pend_d = 1'b1;
          st_d = ctrl_q.powerdown_flag ? qdw_pkg::ST_DONE : qdw_pkg::ST_HIGH;
        end
        default:
          st_d = st_q;
      endcase
      oe_d = ack_d;
    end
    else if (ack_end)
    begin
      ackph_d = 1'b0;
      bit_d = 4'h0;
      oe_d = 1'b0;
      pend_d = 1'b0;
      if (pend_q)
      begin
        words_d = words_q + 8'h01;
        tmp_d[ctrl_q.chan] = new_w;
        case (ctrl_q.upd_sel)
          qdw_pkg::UPD_TEMP: out_d = out_q;
          qdw_pkg::UPD_ONE: out_d[ctrl_q.chan] = new_w;
          default: out_d = tmp_d;
        endcase
      end
    end
    else if (scl_rise && bit_q != qdw_pkg::BITS_PER_BYTE)
      bit_d = bit_q + 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_q <= qdw_pkg::ST_IDLE;
      bit_q <= 4'h0;
      ackph_q <= 1'b0;
      oe_q <= 1'b0;
      pend_q <= 1'b0;
      hs_q <= 1'b0;
      ctrl_q <= '0;
      hi_q <= 8'h00;
      lo_q <= 2'h0;
      words_q <= 8'h00;
      tmp_q <= '0;
      out_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      bit_q <= bit_d;
      ackph_q <= ackph_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      hs_q <= hs_d;
      ctrl_q <= ctrl_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      words_q <= words_d;
      tmp_q <= tmp_d;
      out_q <= out_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign chan_out = out_q;

  // Register slave: one write and one read outstanding; address and data in either order.
  logic awv_q, awv_d, wv_q, wv_d, wstb_q, wstb_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, rd_word;
  logic [1:0] br_q, br_d, rr_q, rr_d, rd_resp;

  assign s_axi_awready = ~awv_q & ~bv_q;
  assign s_axi_wready = ~wv_q & ~bv_q;
  assign s_axi_arready = ~rv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  always_comb
  begin
    rd_resp = qdw_pkg::RESP_OKAY;
    rd_word = 32'h00000000;
    if (s_axi_araddr[1:0] != 2'h0)
      rd_resp = qdw_pkg::RESP_SLVERR;
    else if (s_axi_araddr == qdw_pkg::OFF_CFG)
      rd_word = {29'h0000000, cfg_q};
    else if (s_axi_araddr == qdw_pkg::OFF_STATUS)
    begin
      rd_word[7:0] = ctrl_q;
      rd_word[qdw_pkg::STAT_WORDS_LSB +: 8] = words_q;
      rd_word[qdw_pkg::STAT_STATE_LSB +: 3] = st_q;
      rd_word[qdw_pkg::STAT_HS_BIT] = hs_q;
    end
    else if (s_axi_araddr[7:4] == qdw_pkg::PAGE_OUT)
      rd_word = word32(out_q[s_axi_araddr[3:2]]);
    else if (s_axi_araddr[7:4] == qdw_pkg::PAGE_TEMP)
      rd_word = word32(tmp_q[s_axi_araddr[3:2]]);
    else
      rd_resp = qdw_pkg::RESP_SLVERR;
  end

  always_comb
  begin
    awv_d = awv_q;
    awa_d = awa_q;
    wv_d = wv_q;
    wd_d = wd_q;
    wstb_d = wstb_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    cfg_d = cfg_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awv_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wv_d = 1'b1;
      wd_d = s_axi_wdata;
      wstb_d = s_axi_wstrb[0];
    end
    if (awv_q && wv_q)
    begin
      awv_d = 1'b0;
      wv_d = 1'b0;
      bv_d = 1'b1;
      // Only the configuration word is writable; all else answers with an error.
      if (awa_q == qdw_pkg::OFF_CFG)
      begin
        br_d = qdw_pkg::RESP_OKAY;
        if (wstb_q)
          cfg_d = wd_q[2:0];
      end
      else
        br_d = qdw_pkg::RESP_SLVERR;
    end
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rv_d = 1'b1;
      rd_d = rd_word;
      rr_d = rd_resp;
    end
    else if (rv_q && s_axi_rready)
      rv_d = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      awv_q <= 1'b0;
      awa_q <= 8'h00;
      wv_q <= 1'b0;
      wd_q <= 32'h00000000;
      wstb_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= 2'h0;
      rv_q <= 1'b0;
      rd_q <= 32'h00000000;
      rr_q <= 2'h0;
      cfg_q <= qdw_pkg::CFG_RESET;
    end
    else
    begin
      awv_q <= awv_d;
      awa_q <= awa_d;
      wv_q <= wv_d;
      wd_q <= wd_d;
      wstb_q <= wstb_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      cfg_q <= cfg_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_addr_acked;
    byte_done && st_q == qdw_pkg::ST_ADDR && ack_d;
  endsequence
  a_addr_match: assert property (s_addr_acked |-> rx_byte[7:0] ==
    {qdw_pkg::ADDR_FIXED, apin_s_q[3:2], 1'b0})
    else $error("acknowledged an address that does not match");
  a_entry_nack: assert property (byte_done && st_q == qdw_pkg::ST_ADDR
    && rx_byte[7:3] == qdw_pkg::ENTRY_CODE_TOP |=> !sda_oe && st_q == qdw_pkg::ST_SKIP)
    else $error("entry code was acknowledged");
  a_ack_drive: assert property (s_addr_acked |=> sda_oe && !sda_o && st_q ==
    qdw_pkg::ST_CTRL)
    else $error("address acknowledge not driven");
  a_start_ctx: assert property (start_ev |=> st_q == qdw_pkg::ST_ADDR && !sda_oe)
    else $error("start did not restart addressing");
  a_stop_idle: assert property (stop_ev |=> st_q == qdw_pkg::ST_IDLE && !pend_q)
    else $error("stop did not end the context");
  a_pd_two: assert property (byte_done && st_q == qdw_pkg::ST_DONE |=> !sda_oe)
    else $error("byte after power-down pair acknowledged");
  a_pair_loop: assert property (byte_done && st_q == qdw_pkg::ST_LOW
    && !ctrl_q.powerdown_flag |=> st_q == qdw_pkg::ST_HIGH ##0 pend_q)
    else $error("data pairs do not repeat");
  a_data_pack: assert property (ack_end && pend_q && !ctrl_q.powerdown_flag
    |=> tmp_q[$past(ctrl_q.chan)] == {2'h0, $past(hi_q), $past(lo_q)})
    else $error("data word packed wrongly");
  a_load_one: assert property (ack_end && pend_q && ctrl_q.upd_sel ==
    qdw_pkg::UPD_ONE |=> out_q[ctrl_q.chan] == tmp_q[ctrl_q.chan])
    else $error("selected output not loaded");
  a_load_all: assert property (ack_end && pend_q && ctrl_q.upd_sel ==
    qdw_pkg::UPD_ALL |=> out_q == tmp_q)
    else $error("outputs not all loaded");
  a_apply_edge: assert property (!(ack_end && pend_q) && !srst |=>
    out_q == $past(out_q) || $past(srst))
    else $error("output changed outside acknowledge end");
endmodule : qdw_i2c_receiver

// [pkg/qdw_pkg.sv]
/*
  Constants, field layouts and types for the quad converter serial write receiver.
  Assumes a single 250 MHz register clock and a separate clock taken from the bus clock pin.
*/
// What this block does
// - A write starts with the device address, write bit zero, then a control byte.
// - Control byte: extended address, update select, spare, channel select, power-down flag.
// - The power-down flag chooses power-down settings or conversion data for following bytes.
// - With flag zero, high and low byte pairs repeat until STOP or repeated START.
// - With flag one, exactly two power-down bytes follow the control byte.
// - High byte holds sample bits 9..2; low byte top two bits hold bits 1..0.
// - Matching address, control byte with matching extended address and each data byte are acknowledged by pulling data low.
// - The high-speed entry code is never acknowledged.
// - After the entry code a repeated START and address follow at high speed.
// - A received word is applied at the falling clock ending the low byte acknowledge.
// - Update select 00 writes temporary, 01 also loads that output, 10 loads all.
package qdw_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam logic [4:0] ENTRY_CODE_TOP = 5'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] UPD_TEMP = 2'h0;
  localparam logic [1:0] UPD_ONE = 2'h1;
  localparam logic [1:0] UPD_ALL = 2'h2;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [3:0] PAGE_OUT = 4'h1;
  localparam logic [3:0] PAGE_TEMP = 4'h2;
  localparam logic [2:0] CFG_RESET = 3'h1;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_EXT_LSB = 1;
  localparam int STAT_WORDS_LSB = 8;
  localparam int STAT_STATE_LSB = 16;
  localparam int STAT_HS_BIT = 19;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] ext_addr;
    logic [1:0] upd_sel;
    logic spare;
    logic [1:0] chan;
    logic powerdown_flag;
  } qdw_ctrl_t;

  typedef struct packed {
    logic [1:0] pd_mode;
    logic [9:0] sample;
  } qdw_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_CTRL = 3'h3,
    ST_HIGH = 3'h2,
    ST_LOW = 3'h6,
    ST_DONE = 3'h7,
    ST_SKIP = 3'h5
  } qdw_state_t;
endpackage : qdw_pkg

// [testbench/qdw_bus_master.sv]
/*
  Behavioural two-wire bus master that drives the receiver's clock and data pins.
  Assumes a pull-up on the data line and a 15 ns tick; each clock phase spans two ticks or more.
*/
`timescale 1ns/100ps
module qdw_bus_master
(
  output logic scl_clk,
  output logic sda_line,
  input wire logic sda_o,
  input wire logic sda_oe
);
  localparam int TICK = 15;
  logic sda_drv;
  // Wired AND: the line is low while either party pulls it low, else the pull-up wins.
  assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
  initial
  begin
    scl_clk = 1'b1;
    sda_drv = 1'b1;
  end
  // Serves as a first and as a repeated start.
  task automatic start_cond();
    scl_clk = 1'b0;
    #TICK sda_drv = 1'b1;
    #(2*TICK) scl_clk = 1'b1;
    #(2*TICK) sda_drv = 1'b0;
    #(2*TICK);
  endtask : start_cond
  task automatic stop_cond();
    scl_clk = 1'b0;
    #TICK sda_drv = 1'b0;
    #(2*TICK) scl_clk = 1'b1;
    #(2*TICK) sda_drv = 1'b1;
    #(2*TICK);
  endtask : stop_cond
  // Data changes one tick into the three-tick low phase so it is settled well before the rising clock.
  task automatic put_bit(input logic b, output logic seen);
    scl_clk = 1'b0;
    #TICK sda_drv = b;
    #(2*TICK) scl_clk = 1'b1;
    #TICK seen = sda_line;
    #TICK;
  endtask : put_bit
  task automatic send_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, ack_n);
  endtask : send_byte
endmodule : qdw_bus_master

// [testbench/tb_quad_dac_i2c_write_receiver.sv]
/*
  Self-checking bench for the serial write receiver and its register slave.
  Assumes the bus master model drives the bus pins and the bench drives the register bus.
*/
`timescale 1ns/100ps
module tb_quad_dac_i2c_write_receiver;
  logic ref_clk, srst, scl_clk, sda_line, sda_o, sda_oe, pin_hi, pin_lo;
  qdw_pkg::qdw_word_t [3:0] chan_out;
  logic [7:0] s_axi_awaddr, s_axi_araddr, adr_b;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  int error_cnt, num_checks, words_m;
  qdw_pkg::qdw_word_t tmp_m [4];
  qdw_pkg::qdw_word_t out_m [4];

  qdw_i2c_receiver i_dut (.ref_clk(ref_clk), .srst(srst), .scl_clk(scl_clk), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_pin_hi(pin_hi), .addr_pin_lo(pin_lo),
    .chan_out(chan_out), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1));
  qdw_bus_master i_master (.scl_clk(scl_clk), .sda_line(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic count_wait(inout int n);
    n++;
    if (n > 40)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask : count_wait

  // Ready and valid are sampled at the falling edge, so the rising edge that follows
  // is the one at which the handshake takes place.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    int n;
    n = 0;
    b_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b_ok)
    begin
      @(negedge ref_clk);
      aw_ok = s_axi_awready;
      w_ok = s_axi_wready;
      b_ok = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
      count_wait(n);
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    int n;
    n = 0;
    r_ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!r_ok)
    begin
      @(negedge ref_clk);
      ar_ok = s_axi_arready;
      r_ok = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_ok)
        s_axi_arvalid <= 1'b0;
      count_wait(n);
    end
  endtask : axi_rd

  function automatic qdw_pkg::qdw_word_t word_of(input logic pd, input logic [7:0] hi,
    input logic [7:0] lo);
    word_of = pd ? {hi[7:6], 10'h000} : {2'h0, hi, lo[7:6]};
  endfunction : word_of

  task automatic apply(input logic [1:0] upd, input logic [1:0] ch, input qdw_pkg::qdw_word_t w);
    tmp_m[ch] = w;
    words_m++;
    if (upd == 2'h1)
      out_m[ch] = w;
    if (upd[1])
      out_m = tmp_m;
  endtask : apply

  task automatic cmp_all(input logic [1:0] ch);
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge ref_clk);
    for (int k = 0; k < 4; k++)
      chk("chan_out", chan_out[k], out_m[k]);
    axi_rd({4'h2, ch, 2'h0}, d, r);
    chk("temp_reg", d, {20'h0, tmp_m[ch]});
    axi_rd({4'h1, ch, 2'h0}, d, r);
    chk("out_reg", d, {20'h0, out_m[ch]});
  endtask : cmp_all

  task automatic xfer(input logic [7:0] ctl, input int pairs, input logic hs, input logic half);
    logic a, bad;
    logic [7:0] hi, lo;
    logic [31:0] d;
    logic [1:0] r;
    i_master.start_cond();
    if (hs)
    begin
      i_master.send_byte(8'h08 | 8'($urandom_range(7)), a);
      chk("entry_nack", a, 1'b1);
      @(posedge ref_clk);
      axi_rd(qdw_pkg::OFF_STATUS, d, r);
      chk("entry_seen", d[qdw_pkg::STAT_HS_BIT], 1'b1);
      i_master.start_cond();
    end
    i_master.send_byte(adr_b, a);
    chk("addr_ack", a, 1'b0);
    i_master.send_byte(ctl, a);
    chk("ctrl_ack", a, 1'b0);
    for (int k = 0; k < pairs; k++)
    begin
      hi = 8'($urandom);
      lo = 8'($urandom);
      bad = ctl[0] && k > 0;
      if (ctl[0])
      begin
        hi[5:0] = 6'h00;
        lo[7:6] = 2'h0;
      end
      i_master.send_byte(hi, a);
      chk("high_ack", a, bad);
      i_master.send_byte(lo, a);
      chk("low_ack", a, bad);
      if (!bad)
        apply(ctl[5:4], ctl[2:1], word_of(ctl[0], hi, lo));
    end
    // A lone high byte before the stop must leave the temporary and output registers alone.
    if (half)
    begin
      i_master.send_byte(8'h5A, a);
      chk("half_ack", a, ctl[0]);
    end
    i_master.stop_cond();
    @(posedge ref_clk);
    cmp_all(ctl[2:1]);
  endtask : xfer

  task automatic refuse(input logic [7:0] b0, input logic [7:0] b1, input logic ack0);
    logic a;
    i_master.start_cond();
    i_master.send_byte(b0, a);
    chk("refuse_first", a, ack0);
    i_master.send_byte(b1, a);
    chk("refuse_second", a, 1'b1);
    i_master.stop_cond();
  endtask : refuse

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'hC8BA3F69));
    srst = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    words_m = 0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    pin_hi = 1'($urandom);
    pin_lo = 1'($urandom);
    adr_b = {5'h13, pin_hi, pin_lo, 1'b0};
    tmp_m = '{default: '0};
    out_m = '{default: '0};
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cmp_all(2'h0);
    axi_rd(qdw_pkg::OFF_CFG, d, r);
    chk("cfg_reset", d, 32'h1);
    axi_rd(8'h44, d, r);
    chk("unmapped_rd", r, 32'h2);
    axi_wr(qdw_pkg::OFF_STATUS, 32'h0, r);
    chk("readonly_wr", r, 32'h2);
    axi_wr(qdw_pkg::OFF_CFG, 32'h1, r);
    chk("cfg_wr", r, 32'h0);
    for (int i = 0; i < 16; i++)
      xfer({2'h0, 2'(i), 1'($urandom), 2'($urandom), 1'(i >> 2)}, 1 + $urandom_range(2),
        i >= 8, 1'($urandom));
    refuse(adr_b ^ 8'h02, 8'h10, 1'b1);
    refuse(adr_b | 8'h01, 8'h10, 1'b1);
    refuse(adr_b, 8'h50, 1'b0);
    // A write with the low byte lane off must leave the configuration alone.
    @(posedge ref_clk);
    s_axi_wstrb <= 4'h0;
    axi_wr(qdw_pkg::OFF_CFG, 32'h0, r);
    chk("cfg_masked_wr", r, 32'h0);
    s_axi_wstrb <= 4'hF;
    axi_rd(qdw_pkg::OFF_CFG, d, r);
    chk("cfg_masked", d, 32'h1);
    axi_wr(qdw_pkg::OFF_CFG, 32'h0, r);
    chk("cfg_off_wr", r, 32'h0);
    refuse(adr_b, 8'h10, 1'b1);
    @(posedge ref_clk);
    axi_wr(qdw_pkg::OFF_CFG, 32'h3, r);
    axi_rd(qdw_pkg::OFF_CFG, d, r);
    chk("cfg_ext", d, 32'h3);
    xfer(8'h52, 2, 1'b0, 1'b0);
    cmp_all(2'h3);
    axi_rd(qdw_pkg::OFF_STATUS, d, r);
    chk("status", d, {16'h0000, 8'(words_m), 8'h52});
    wrap_up();
  end
endmodule : tb_quad_dac_i2c_write_receiver
